// File: usr_pkg.sv
package usr_pkg;
  // Register offsets on the plain register port.
  localparam logic [7:0] REG_TX_STATUS_CTRL = 8'h98;
  localparam logic [7:0] REG_RX_STATUS_CTRL = 8'h18;
  localparam logic [7:0] REG_RX_BUFFER = 8'h1A;
  localparam logic [7:0] REG_BAUD_GEN = 8'h99;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h8C;

  // Transmit status and control fields.
  localparam int TX_CLK_SRC_BIT = 7;
  localparam int TX_NINE_SEL_BIT = 6;
  localparam int TX_ENABLE_BIT = 5;
  localparam int TX_SYNC_BIT = 4;
  localparam int TX_HIGH_BAUD_BIT = 2;
  localparam int TX_SHIFT_EMPTY_BIT = 1;
  localparam int TX_NINTH_BIT = 0;
  localparam logic [7:0] TX_WRITE_MASK = 8'hF5;

  // Receive status and control fields.
  localparam int RX_PORT_EN_BIT = 7;
  localparam int RX_NINE_SEL_BIT = 6;
  localparam int RX_SINGLE_BIT = 5;
  localparam int RX_CONT_BIT = 4;
  localparam int RX_FRAME_ERR_BIT = 2;
  localparam int RX_OVERRUN_BIT = 1;
  localparam int RX_NINTH_BIT = 0;

  // Interrupt status and mask fields.
  localparam int IRQ_RX_WORD_BIT = 0;
  localparam int IRQ_OVERRUN_BIT = 1;
  localparam int IRQ_FRAME_BIT = 2;
  localparam int IRQ_W = 3;

  // Values after reset.
  localparam logic [7:0] TX_CTRL_RST = 8'h00;
  localparam logic [7:0] RX_CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // Oversampling and bit counts.
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [1:0] LOW_BAUD_PRESCALE_LAST = 2'h3;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam int ENTRY_W = 10;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } usr_rx_state_t;

  typedef enum logic [1:0] {
    MODE_ASYNC = 2'b00,
    MODE_SYNC_MASTER = 2'b01,
    MODE_SYNC_SLAVE = 2'b10
  } usr_mode_t;
endpackage : usr_pkg

// File: usr_fifo_if.sv
`timescale 1ns/100ps
interface usr_fifo_if #(
  parameter int W = 10
);
  logic push;
  logic pop;
  logic full;
  logic empty;
  logic [W-1:0] wdata;
  logic [W-1:0] head;

  modport user (output push, output pop, output wdata, input full, input empty, input head);
  modport store (input push, input pop, input wdata, output full, output empty, output head);
endinterface : usr_fifo_if

// File: usr_rx_fifo.sv
`timescale 1ns/100ps
module usr_rx_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  usr_fifo_if.store fifo
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic do_push;
  logic do_pop;

  assign fifo.full = (count_ff == CW'(DEPTH));
  assign fifo.empty = (count_ff == '0);
  assign fifo.head = mem_ff[rd_ptr_ff];
  // A push into a full store is dropped; the owner flags it as an overrun.
  assign do_push = fifo.push && !fifo.full;
  assign do_pop = fifo.pop && !fifo.empty;

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff] <= fifo.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (do_pop && !do_push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule : usr_rx_fifo

// File: usr_uart_top.sv
`timescale 1ns/100ps
// Overview of operation
// - Async, sync master and sync slave modes.
// - Nine-bit select; low control bit is ninth.
// - Recovery at sixteen times baud; shifter per bit.
// - Async reception only while continuous enable set.
// - After stop bit, move word into FIFO.
// - Transfer sets full flag; interrupt needs enable.
// - Full flag read-only, clears when buffer empty.
// - Two-entry FIFO; third byte may shift in.
// - Full at third stop bit: overrun, drop word.
// - Overrun cleared only by receive enable toggle.
// - Overrun blocks every transfer into FIFO.
// - Stop bit sampled low sets framing error.
// - Framing error and ninth bit stored per entry.
module usr_uart_top #(
  parameter int FIFO_DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [1:0] port_b_direction_i,
  input wire logic receive_data_pin_i,
  input wire logic transmit_clock_pin_i,
  output logic transmit_clock_pin_o,
  output logic transmit_clock_pin_oe_o,
  output logic [1:0] mode_o,
  output logic transmit_enable_o,
  output logic nine_bit_tx_select_o,
  output logic ninth_tx_bit_o,
  output logic receive_full_flag_o,
  output logic irq_o
);
  usr_fifo_if #(.W(usr_pkg::ENTRY_W)) rxq ();

  usr_rx_fifo #(.W(usr_pkg::ENTRY_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .fifo(rxq.store)
  );

  // Short local names for the receiver states keep the state machine readable.
  localparam usr_pkg::usr_rx_state_t RX_IDLE = usr_pkg::RX_IDLE;
  localparam usr_pkg::usr_rx_state_t RX_START = usr_pkg::RX_START;
  localparam usr_pkg::usr_rx_state_t RX_DATA = usr_pkg::RX_DATA;
  localparam usr_pkg::usr_rx_state_t RX_STOP = usr_pkg::RX_STOP;

  logic [7:0] tx_ctrl_ff;
  logic [7:0] rx_ctrl_ff;
  logic [7:0] baud_ff;
  logic [usr_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [usr_pkg::IRQ_W-1:0] irq_mask_ff;
  logic [7:0] rdata_ff;
  logic [7:0] brg_cnt_ff;
  logic [1:0] prescale_ff;
  logic sclk_ff;
  logic rx_prev_ff;
  logic overrun_ff;
  usr_pkg::usr_rx_state_t state_ff;
  logic [3:0] ovs_ff;
  logic [3:0] bits_ff;
  logic [8:0] shift_ff;

  logic wr_tx;
  logic wr_rx;
  logic rd_buf;
  logic port_on;
  logic sync_mode;
  logic clk_master;
  logic rx_nine;
  logic rx_active;
  logic brg_tick;
  logic samp_tick;
  logic stop_done;
  logic word_push;
  logic [usr_pkg::IRQ_W-1:0] irq_event;
  logic [usr_pkg::IRQ_W-1:0] irq_clear;
  logic [7:0] rx_status;
  logic [7:0] nxt_rdata;
  usr_pkg::usr_mode_t mode;

  assign wr_tx = wr_i && (addr_i == usr_pkg::REG_TX_STATUS_CTRL);
  assign wr_rx = wr_i && (addr_i == usr_pkg::REG_RX_STATUS_CTRL);
  assign rd_buf = rd_i && (addr_i == usr_pkg::REG_RX_BUFFER);
  // The pins only belong to the port once enable and both directions are set.
  assign port_on = rx_ctrl_ff[usr_pkg::RX_PORT_EN_BIT] && (&port_b_direction_i);
  assign sync_mode = tx_ctrl_ff[usr_pkg::TX_SYNC_BIT];
  assign clk_master = tx_ctrl_ff[usr_pkg::TX_CLK_SRC_BIT];
  assign rx_nine = rx_ctrl_ff[usr_pkg::RX_NINE_SEL_BIT];

  always_comb begin
    if (!sync_mode) begin
      mode = usr_pkg::MODE_ASYNC;
    end else if (clk_master) begin
      mode = usr_pkg::MODE_SYNC_MASTER;
    end else begin
      mode = usr_pkg::MODE_SYNC_SLAVE;
    end
  end

  assign mode_o = mode;
  assign transmit_enable_o = tx_ctrl_ff[usr_pkg::TX_ENABLE_BIT];
  assign nine_bit_tx_select_o = tx_ctrl_ff[usr_pkg::TX_NINE_SEL_BIT];
  assign ninth_tx_bit_o = tx_ctrl_ff[usr_pkg::TX_NINTH_BIT];

  // Sync master drives the bit clock; slave leaves the pin to the far end.
  always_comb begin
    transmit_clock_pin_o = 1'b1;
    transmit_clock_pin_oe_o = 1'b0;
    unique case (mode)
      usr_pkg::MODE_ASYNC: begin
        transmit_clock_pin_oe_o = port_on && transmit_enable_o;
      end
      usr_pkg::MODE_SYNC_MASTER: begin
        transmit_clock_pin_o = sclk_ff;
        transmit_clock_pin_oe_o = port_on;
      end
      usr_pkg::MODE_SYNC_SLAVE: begin
        transmit_clock_pin_oe_o = 1'b0;
      end
      default: begin
        transmit_clock_pin_oe_o = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_ctrl_ff <= usr_pkg::TX_CTRL_RST;
      rx_ctrl_ff <= usr_pkg::RX_CTRL_RST;
      baud_ff <= usr_pkg::BAUD_RST;
      irq_mask_ff <= usr_pkg::IRQ_MASK_RST;
    end else if (wr_i) begin
      if (wr_tx) begin
        tx_ctrl_ff <= wdata_i & usr_pkg::TX_WRITE_MASK;
      end
      if (wr_rx) begin
        rx_ctrl_ff <= {wdata_i[7:4], 4'h0};
      end
      if (addr_i == usr_pkg::REG_BAUD_GEN) begin
        baud_ff <= wdata_i;
      end
      if (addr_i == usr_pkg::REG_IRQ_MASK) begin
        irq_mask_ff <= wdata_i[usr_pkg::IRQ_W-1:0];
      end
    end
  end

  // Baud generator: one tick per reload; low speed divides by four more.
  assign brg_tick = (brg_cnt_ff == 8'h00);
  assign samp_tick = brg_tick && (tx_ctrl_ff[usr_pkg::TX_HIGH_BAUD_BIT]
                     || prescale_ff == usr_pkg::LOW_BAUD_PRESCALE_LAST);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      brg_cnt_ff <= usr_pkg::BAUD_RST;
      prescale_ff <= 2'h0;
      sclk_ff <= 1'b1;
    end else begin
      brg_cnt_ff <= brg_tick ? baud_ff : brg_cnt_ff - 1'b1;
      if (brg_tick) begin
        prescale_ff <= prescale_ff + 1'b1;
      end
      if (brg_tick && mode == usr_pkg::MODE_SYNC_MASTER) begin
        sclk_ff <= ~sclk_ff;
      end
    end
  end

  // Dropping continuous enable is the receive logic reset.
  assign rx_active = port_on && !sync_mode && rx_ctrl_ff[usr_pkg::RX_CONT_BIT];
  assign stop_done = (state_ff == RX_STOP) && samp_tick && (ovs_ff == usr_pkg::OVS_LAST);
  assign word_push = stop_done && !rxq.full && !overrun_ff;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_prev_ff <= 1'b1;
    end else begin
      rx_prev_ff <= receive_data_pin_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= RX_IDLE;
      ovs_ff <= 4'h0;
      bits_ff <= 4'h0;
      shift_ff <= 9'h000;
    end else if (!rx_active) begin
      state_ff <= RX_IDLE;
      ovs_ff <= 4'h0;
    end else begin
      unique case (state_ff)
        RX_IDLE: begin
          if (rx_prev_ff && !receive_data_pin_i) begin
            state_ff <= RX_START;
            ovs_ff <= 4'h0;
          end
        end
        RX_START: begin
          if (samp_tick) begin
            ovs_ff <= ovs_ff + 1'b1;
            if (ovs_ff == usr_pkg::OVS_MID) begin
              ovs_ff <= 4'h0;
              bits_ff <= 4'h0;
              // A glitch shorter than half a bit is not a start bit.
              state_ff <= receive_data_pin_i ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (samp_tick) begin
            ovs_ff <= ovs_ff + 1'b1;
            if (ovs_ff == usr_pkg::OVS_LAST) begin
              shift_ff <= {receive_data_pin_i, shift_ff[8:1]};
              bits_ff <= bits_ff + 1'b1;
              if (bits_ff + 1'b1 == (rx_nine ? usr_pkg::DATA_BITS_9 : usr_pkg::DATA_BITS_8)) begin
                state_ff <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (samp_tick) begin
            ovs_ff <= ovs_ff + 1'b1;
            if (ovs_ff == usr_pkg::OVS_LAST) begin
              state_ff <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Overrun is set only by a stop bit meeting a full FIFO.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      overrun_ff <= 1'b0;
    end else if (!rx_ctrl_ff[usr_pkg::RX_CONT_BIT]) begin
      overrun_ff <= 1'b0;
    end else if (stop_done && rxq.full) begin
      overrun_ff <= 1'b1;
    end
  end

  // Entry layout: framing error, ninth bit, data byte.
  assign rxq.push = word_push;
  assign rxq.wdata = {!receive_data_pin_i,
                      rx_nine ? shift_ff[8] : 1'b0,
                      rx_nine ? shift_ff[7:0] : shift_ff[8:1]};
  assign rxq.pop = rd_buf && !rxq.empty;
  assign receive_full_flag_o = !rxq.empty;

  // Status shows the head entry, so it must be read before the buffer.
  assign rx_status = {rx_ctrl_ff[7:4], 1'b0,
                      rxq.head[9] && !rxq.empty,
                      overrun_ff,
                      rxq.head[8] && !rxq.empty};

  assign irq_event = {stop_done && receive_data_pin_i == 1'b0 && word_push,
                      stop_done && rxq.full && !overrun_ff,
                      word_push};
  assign irq_clear = (wr_i && addr_i == usr_pkg::REG_IRQ_STATUS)
                     ? wdata_i[usr_pkg::IRQ_W-1:0] : 3'h0;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_stat_ff <= 3'h0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clear) | irq_event;
    end
  end

  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  always_comb begin
    nxt_rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        usr_pkg::REG_TX_STATUS_CTRL: begin
          // No transmit data path here, so the shifter always reads empty.
          nxt_rdata = tx_ctrl_ff | (8'h01 << usr_pkg::TX_SHIFT_EMPTY_BIT);
        end
        usr_pkg::REG_RX_STATUS_CTRL: nxt_rdata = rx_status;
        usr_pkg::REG_RX_BUFFER: nxt_rdata = rxq.empty ? 8'h00 : rxq.head[7:0];
        usr_pkg::REG_BAUD_GEN: nxt_rdata = baud_ff;
        usr_pkg::REG_IRQ_STATUS: nxt_rdata = {5'h00, irq_stat_ff};
        usr_pkg::REG_IRQ_MASK: nxt_rdata = {5'h00, irq_mask_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_rx_gated_idle: assert property (!rx_active |=> state_ff == RX_IDLE)
    else $error("receiver left idle while reception disabled");
  a_stop_pushes_word: assert property (
    stop_done && !rxq.full && !overrun_ff |=> !rxq.empty && receive_full_flag_o)
    else $error("completed frame not stored");
  a_overrun_set: assert property (
    stop_done && rxq.full && rx_ctrl_ff[usr_pkg::RX_CONT_BIT] |=> overrun_ff)
    else $error("overrun not flagged on full buffer");
  a_overrun_blocks: assert property (overrun_ff |-> !rxq.push)
    else $error("transfer while overrun set");
  a_overrun_no_fill: assert property (overrun_ff && rxq.empty |=> rxq.empty)
    else $error("buffer filled while overrun set");
  a_overrun_sticky: assert property (
    overrun_ff && rx_ctrl_ff[usr_pkg::RX_CONT_BIT] ##1 rx_ctrl_ff[usr_pkg::RX_CONT_BIT]
    |-> overrun_ff)
    else $error("overrun cleared without enable toggle");
  a_overrun_clears: assert property (
    !rx_ctrl_ff[usr_pkg::RX_CONT_BIT] |=> !overrun_ff)
    else $error("overrun survived receive reset");
  a_flag_empties: assert property (
    rd_buf && rxq.full && !rxq.push ##1 rd_buf && !rxq.push |=> !receive_full_flag_o)
    else $error("full flag stuck after draining");
  a_frame_error: assert property (
    stop_done && !receive_data_pin_i && rxq.empty && !overrun_ff
    |=> rx_status[usr_pkg::RX_FRAME_ERR_BIT])
    else $error("framing error not reported");
  a_start_on_fall: assert property (
    state_ff == RX_IDLE ##1 state_ff == RX_START
    |-> $past(rx_prev_ff) && !$past(receive_data_pin_i))
    else $error("start without falling edge");
  a_start_centre: assert property (
    state_ff == RX_START ##1 state_ff == RX_DATA |-> $past(ovs_ff) == usr_pkg::OVS_MID)
    else $error("start bit not sampled at centre");
  a_read_one_cycle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside answer cycle");
endmodule : usr_uart_top

// File: usr_serial_peer.sv
`timescale 1ns/100ps
module usr_serial_peer #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_i,
  output logic line_o
);
  // Bit length in clocks; the bench may change it between frames for another baud.
  int bit_clks = BIT_CLKS;

  // The line idles high, as a released receive line would with its pull-up.
  initial begin
    line_o = 1'b1;
  end

  // Holds one level on the line for one bit time, changing just after an edge.
  task automatic drive(input logic lvl);
    @(posedge clk_i);
    line_o <= lvl;
    repeat (bit_clks - 1) @(posedge clk_i);
  endtask : drive

  // Low start bit, data LSB first, stop level, then one idle bit for the next edge.
  task automatic send(input logic [8:0] word, input int nbits, input logic stop);
    drive(1'b0);
    for (int i = 0; i < nbits; i++) begin
      drive(word[i]);
    end
    drive(stop);
    drive(1'b1);
  endtask : send

  // A low pulse far shorter than half a bit, which must not count as a start.
  task automatic glitch();
    @(posedge clk_i);
    line_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    line_o <= 1'b1;
    repeat (bit_clks * 12) @(posedge clk_i);
  endtask : glitch
endmodule : usr_serial_peer

// File: usr_uart_top_tb.sv
`timescale 1ns/100ps
module usr_uart_top_tb;
  localparam logic [7:0] TXC = usr_pkg::REG_TX_STATUS_CTRL;
  localparam logic [7:0] RXC = usr_pkg::REG_RX_STATUS_CTRL;
  localparam logic [7:0] BUF = usr_pkg::REG_RX_BUFFER;
  localparam logic [7:0] IST = usr_pkg::REG_IRQ_STATUS;
  localparam logic [7:0] IMK = usr_pkg::REG_IRQ_MASK;

  typedef struct packed {
    logic [8:0] word;
    logic stop;
    logic [7:0] exp_status;
    logic [7:0] exp_data;
  } usr_row_t;

  // Nine-bit reception, port and continuous enable on.
  localparam usr_row_t ROWS [4] = '{
    '{9'h055, 1'b1, 8'hD0, 8'h55},
    '{9'h1A3, 1'b1, 8'hD1, 8'hA3},
    '{9'h000, 1'b1, 8'hD0, 8'h00},
    '{9'h1FF, 1'b0, 8'hD5, 8'hFF}
  };

  logic clk_i;
  logic rstn_i;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [7:0] rdata_o;
  logic [1:0] dir;
  logic rx_line;
  logic ck_o;
  logic ck_oe;
  logic [1:0] mode_o;
  logic tx_en;
  logic nine_sel;
  logic ninth_tx;
  logic full;
  logic irq_o;
  logic ck_prev;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  usr_uart_top dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .port_b_direction_i(dir),
    .receive_data_pin_i(rx_line), .transmit_clock_pin_i(1'b1),
    .transmit_clock_pin_o(ck_o), .transmit_clock_pin_oe_o(ck_oe), .mode_o(mode_o),
    .transmit_enable_o(tx_en), .nine_bit_tx_select_o(nine_sel),
    .ninth_tx_bit_o(ninth_tx), .receive_full_flag_o(full), .irq_o(irq_o)
  );

  // Baud divisor 1 with high baud gives 16 ticks of 2 clocks per bit.
  usr_serial_peer #(.BIT_CLKS(32)) peer (
    .clk_i(clk_i),
    .line_o(rx_line)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe edge.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o, exp);
  endtask : rd_chk

  // Two reads with no gap: the second strobe stands at the edge that answers the first.
  task automatic rd_pair(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    #1;
    check(rdata_o, e0);
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o, e1);
  endtask : rd_pair

  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask : settle

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    rstn_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    dir = 2'b11;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd_chk(TXC, 8'h02);
    rd_chk(RXC, 8'h00);
    rd_chk(IMK, 8'h00);
    rd_chk(8'h55, 8'h00);
    $display("test reset values done");

    wr(usr_pkg::REG_BAUD_GEN, 8'h01);
    wr(TXC, 8'h04);
    wr(RXC, 8'hD0);
    foreach (ROWS[i]) begin
      peer.send(ROWS[i].word, 9, ROWS[i].stop);
      check({7'h00, full}, 8'h01);
      rd_chk(RXC, ROWS[i].exp_status);
      rd_chk(BUF, ROWS[i].exp_data);
      settle();
      check({7'h00, full}, 8'h00);
    end
    $display("test frame rows done");

    rd_chk(IST, 8'h05);
    wr(IST, 8'h07);
    for (int i = 0; i < 3; i++) begin
      peer.send(9'h010 + 9'(i), 9, 1'b1);
    end
    rd_chk(RXC, 8'hD2);
    rd_pair(BUF, 8'h10, 8'h11);
    rd_chk(BUF, 8'h00);
    peer.send(9'h033, 9, 1'b1);
    check({7'h00, full}, 8'h00);
    wr(RXC, 8'hC0);
    wr(RXC, 8'hD0);
    rd_chk(RXC, 8'hD0);
    $display("test overrun done");

    rd_chk(IST, 8'h03);
    check({7'h00, irq_o}, 8'h00);
    wr(IMK, 8'h01);
    settle();
    check({7'h00, irq_o}, 8'h01);
    wr(IST, 8'h01);
    settle();
    check({7'h00, irq_o}, 8'h00);
    $display("test interrupt done");

    wr(RXC, 8'hC0);
    peer.send(9'h066, 9, 1'b1);
    check({7'h00, full}, 8'h00);
    wr(RXC, 8'hD0);
    peer.glitch();
    check({7'h00, full}, 8'h00);
    peer.send(9'h0A5, 9, 1'b1);
    rd_chk(BUF, 8'hA5);
    $display("test enable and start done");

    wr(usr_pkg::REG_BAUD_GEN, 8'h00);
    wr(TXC, 8'h00);
    wr(RXC, 8'h90);
    peer.bit_clks = 64;
    peer.send(9'h0C3, 8, 1'b1);
    rd_chk(RXC, 8'h90);
    rd_chk(BUF, 8'hC3);
    peer.bit_clks = 32;
    wr(usr_pkg::REG_BAUD_GEN, 8'h01);
    $display("test low baud eight bit done");

    wr(TXC, 8'hFF);
    rd_chk(TXC, 8'hF7);
    check({5'h00, nine_sel, tx_en, ninth_tx}, 8'h07);
    check({6'h00, mode_o}, 8'h01);
    check({7'h00, ck_oe}, 8'h01);
    ck_prev = ck_o;
    settle();
    settle();
    check({7'h00, ck_o ^ ck_prev}, 8'h01);
    @(posedge clk_i);
    dir <= 2'b01;
    settle();
    check({7'h00, ck_oe}, 8'h00);
    @(posedge clk_i);
    dir <= 2'b11;
    wr(TXC, 8'h10);
    settle();
    check({6'h00, mode_o}, 8'h02);
    check({7'h00, ck_oe}, 8'h00);
    wr(TXC, 8'h04);
    settle();
    check({6'h00, mode_o}, 8'h00);
    check({6'h00, ck_oe, ck_o}, 8'h01);
    $display("test transmit control done");

    check({7'h00, irq_o}, 8'h01);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd_chk(TXC, 8'h02);
    rd_chk(IMK, 8'h00);
    check({6'h00, full, irq_o}, 8'h00);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule : usr_uart_top_tb
